// File: hdl/astl_pkg.sv
/*
 acquisition start trigger (legacy mode) package: register map, fields,
 reset values, modes and timing constants.
 assumes a 10 MHz pclk and a 32-bit APB slave interface.
*/
package astl_pkg;
   localparam int unsigned CLK_HZ          = 10_000_000;
   localparam int unsigned CYC_PER_US      = CLK_HZ / 1_000_000;
   // register byte addresses
   localparam logic [11:0] ADDR_CTRL       = 12'h000;
   localparam logic [11:0] ADDR_CMD        = 12'h004;
   localparam logic [11:0] ADDR_EXPO       = 12'h008;
   localparam logic [11:0] ADDR_RATE       = 12'h00C;
   localparam logic [11:0] ADDR_MAXRATE    = 12'h010;
   localparam logic [11:0] ADDR_STATUS     = 12'h014;
   localparam logic [11:0] ADDR_OVTCNT     = 12'h018;
   // control fields
   localparam int unsigned CTRL_TRIG_EN    = 0;
   localparam int unsigned CTRL_ORIGIN_LSB = 1;
   localparam int unsigned CTRL_EDGE       = 3;
   localparam int unsigned CTRL_TARGET     = 4;
   localparam int unsigned CTRL_EXPO_KIND  = 5;
   localparam int unsigned CTRL_CAPTURE    = 6;
   localparam int unsigned CTRL_RATE_EN    = 7;
   // command fields (write one, self clearing)
   localparam int unsigned CMD_BEGIN       = 0;
   localparam int unsigned CMD_END         = 1;
   localparam int unsigned CMD_HOST_TRIG   = 2;
   // status fields
   localparam int unsigned STAT_WAITING    = 0;
   localparam int unsigned STAT_EXPOSING   = 1;
   localparam int unsigned STAT_ACTIVE     = 2;
   localparam int unsigned STAT_OVT        = 3;
   // reset values
   localparam logic [7:0]  CTRL_RST        = 8'h00;
   localparam logic [19:0] EXPO_RST_US     = 20'h00BB8;
   localparam logic [19:0] MAXRATE_RST     = 20'h0001E;
   localparam logic [19:0] RATE_RST        = 20'h0001E;
   // frame period at 1 fps, in cycles
   localparam logic [31:0] FPS1_CYCLES     = 32'(CLK_HZ);

   typedef enum logic [1:0] {
      ASTL_ORIG_HOST  = 2'b00,
      ASTL_ORIG_LINE1 = 2'b01,
      ASTL_ORIG_LINE2 = 2'b10
   } astl_origin_t;

   typedef enum logic [1:0] {
      ASTL_IDLE   = 2'b00,
      ASTL_WAIT   = 2'b01,
      ASTL_EXPOSE = 2'b10,
      ASTL_HOLD   = 2'b11
   } astl_state_t;

   // cycles for a period of rate fps, rounded down, never below one
   function automatic logic [31:0] astl_period(input logic [19:0] fps);
      logic [31:0] p;
      p = 32'h00000001;
      if (fps != 20'h00000)
         p = FPS1_CYCLES / {12'h000, fps};
      if (p == 32'h00000000)
         p = 32'h00000001;
      return p;
   endfunction
endpackage

// File: hdl/astl_sync.sv
/*
 two-flop synchroniser for one asynchronous input line.
 assumes a single pclk domain; the first flop feeds only the second.
*/
`timescale 1ns/1ps
`default_nettype none
module astl_sync (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // line
   input  wire logic line_async,
   output logic      line_sync
);
   typedef struct packed {
      logic meta;
      logic sync;
   } astl_sync_t;
   astl_sync_t s_r, s_nxt;

   always_comb begin
      s_nxt.meta = line_async;
      s_nxt.sync = s_r.meta;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign line_sync = s_r.sync;
endmodule
`default_nettype wire

// File: hdl/astl_edge.sv
/*
 edge qualifier on an already synchronised line.
 rise_mode high selects low-to-high, low selects high-to-low.
*/
`timescale 1ns/1ps
`default_nettype none
module astl_edge (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // line and mode
   input  wire logic line_sync,
   input  wire logic rise_mode,
   // result
   output logic      edge_hit
);
   typedef struct packed {
      logic last;
   } astl_edge_t;
   astl_edge_t e_r, e_nxt;

   always_comb begin
      e_nxt.last = line_sync;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         e_r <= '0;
      end else begin
         e_r <= e_nxt;
      end
   end

   // only the chosen transition counts
   assign edge_hit = rise_mode ? (line_sync & ~e_r.last)
                               : (~line_sync & e_r.last); // R7
endmodule
`default_nettype wire

// File: hdl/astl_trigger.sv
/*
 acquisition start trigger control, legacy mode, with an APB slave.
 assumes host software on APB and two asynchronous trigger input lines;
 frame readout and the standard-mode frame start trigger live elsewhere.
*/
// The APB slave port and the placing of the registers were chosen for this implementation.
// How it works
// [R1] trigger mode off: exposure length comes from programmed duration.
// [R2] trigger mode on: outside party supplies one trigger per frame.
// [R3] trigger mode on: one source chosen, host command, line 1 or 2.
// [R4] each host trigger command counts as one start trigger.
// [R5] line source: trigger derived from the chosen input line.
// [R6] software sets edge polarity whenever a line source is used.
// [R7] rising mode takes low-to-high only, falling mode high-to-low only.
// [R8] triggers are acted on only while in waiting status.
// [R9] host source: exposure timed from programmed duration.
// [R10] line source: timed exposure or exposure following the line level.
// [R11] host trigger while waiting starts exposure.
// [R12] exposure start leaves waiting; waiting returns once ready again.
// [R13] software selects timed exposure before using host triggers.
// [R14] host triggers while not ready are dropped without acquisition.
// [R15] host triggered frame rate follows the command rate.
// [R16] host should not trigger above the maximum frame rate.
// [R17] host command triggers only while target points at start trigger.
// [R18] mode off, single frame: one internal trigger per begin command.
// [R19] mode off, continuous: internal triggers repeat until end command.
// [R20] internal rate: programmed when enabled and below maximum, else max.
// [R21] line trigger during timed exposure ignored, raises overtrigger event.
// [R22] each line passes a two-stage synchroniser before edge detection.
`timescale 1ns/1ps
`default_nettype none
module astl_trigger
   import astl_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // trigger lines
   input  wire logic        line1_in,
   input  wire logic        line2_in,
   // frame control
   output logic             expose_active,
   output logic             frame_start,
   output logic             overtrig_event,
   output logic             waiting_status
);
   import astl_pkg::*;

   typedef struct packed {
      logic [7:0]  ctrl;
      logic [19:0] expo_duration_us;
      logic [19:0] internal_rate_fps;
      logic [19:0] max_rate_fps;
      astl_state_t st;
      logic [31:0] expo_cnt;
      logic [31:0] rate_cnt;
      logic        continuous_run;
      logic        pending_internal;
      logic        width_mode;
      logic        ovt_sticky;
      logic [15:0] ovt_count;
      logic        frame_start;
      logic        ovt_pulse;
      logic [31:0] rdata;
   } astl_state_s_t;
   astl_state_s_t s_r, s_nxt;

   logic l1_sync, l2_sync, l1_hit, l2_hit;
   logic wr_acc, rd_acc, addr_ok;
   logic trig_enable_sel, trig_edge_polarity, trig_target_sel;
   logic expo_kind_sel, capture_kind_sel, internal_rate_en;
   logic host_trig_cmd, capture_begin_cmd, capture_end_cmd;
   logic [1:0]  trig_origin_sel;
   logic        ext_capture_trig, ext_level, any_trig, rate_tick;
   logic [19:0] eff_rate;
   logic [31:0] expo_cycles;

   // synchronise then qualify each line
   astl_sync u_sync1 (.pclk(pclk), .presetn(presetn),
                      .line_async(line1_in), .line_sync(l1_sync)); // R22
   astl_sync u_sync2 (.pclk(pclk), .presetn(presetn),
                      .line_async(line2_in), .line_sync(l2_sync)); // R22
   astl_edge u_edge1 (.pclk(pclk), .presetn(presetn), .line_sync(l1_sync),
                      .rise_mode(trig_edge_polarity), .edge_hit(l1_hit));
   astl_edge u_edge2 (.pclk(pclk), .presetn(presetn), .line_sync(l2_sync),
                      .rise_mode(trig_edge_polarity), .edge_hit(l2_hit));

   function automatic logic addr_mapped(input logic [11:0] a);
      logic ok;
      ok = 1'b0;
      if (a == ADDR_CTRL) ok = 1'b1;
      else if (a == ADDR_CMD) ok = 1'b1;
      else if (a == ADDR_EXPO) ok = 1'b1;
      else if (a == ADDR_RATE) ok = 1'b1;
      else if (a == ADDR_MAXRATE) ok = 1'b1;
      else if (a == ADDR_STATUS) ok = 1'b1;
      else if (a == ADDR_OVTCNT) ok = 1'b1;
      return ok;
   endfunction

   assign addr_ok = addr_mapped(paddr);
   assign wr_acc  = psel & penable & pwrite;
   assign rd_acc  = psel & ~penable & ~pwrite;

   assign trig_enable_sel    = s_r.ctrl[CTRL_TRIG_EN];
   assign trig_origin_sel    = s_r.ctrl[CTRL_ORIGIN_LSB +: 2];
   assign trig_edge_polarity = s_r.ctrl[CTRL_EDGE]; // R6
   assign trig_target_sel    = s_r.ctrl[CTRL_TARGET];
   assign expo_kind_sel      = s_r.ctrl[CTRL_EXPO_KIND];
   assign capture_kind_sel   = s_r.ctrl[CTRL_CAPTURE];
   assign internal_rate_en   = s_r.ctrl[CTRL_RATE_EN];

   assign capture_begin_cmd = wr_acc & addr_ok & (paddr == ADDR_CMD)
                              & pwdata[CMD_BEGIN];
   assign capture_end_cmd   = wr_acc & addr_ok & (paddr == ADDR_CMD)
                              & pwdata[CMD_END];
   // the command is a trigger only with the start trigger targeted
   assign host_trig_cmd     = wr_acc & addr_ok & (paddr == ADDR_CMD)
                              & pwdata[CMD_HOST_TRIG] & trig_target_sel; // R17

   // only the selected line drives the external trigger; host origin drives none
   always_comb begin
      ext_capture_trig = 1'b0;
      ext_level        = 1'b0;
      if (trig_origin_sel == ASTL_ORIG_LINE1) begin
         ext_capture_trig = l1_hit; // R5
         ext_level        = (l1_sync == trig_edge_polarity);
      end else if (trig_origin_sel == ASTL_ORIG_LINE2) begin
         ext_capture_trig = l2_hit; // R5
         ext_level        = (l2_sync == trig_edge_polarity);
      end
   end

   // host origin uses the command, line origins the qualified edge
   assign any_trig = (trig_origin_sel == ASTL_ORIG_HOST) ? host_trig_cmd
                                                         : ext_capture_trig; // R3 R4

   // clamp programmed rate to the maximum
   assign eff_rate = (internal_rate_en && s_r.internal_rate_fps != 20'h00000
                      && s_r.internal_rate_fps < s_r.max_rate_fps)
                     ? s_r.internal_rate_fps : s_r.max_rate_fps; // R20
   assign rate_tick = (s_r.rate_cnt == 32'h00000000);
   assign expo_cycles = ({12'h000, s_r.expo_duration_us} * CYC_PER_US == 0)
                        ? 32'h00000001
                        : 32'({12'h000, s_r.expo_duration_us} * CYC_PER_US);

   always_comb begin
      s_nxt = s_r;
      s_nxt.frame_start = 1'b0;
      s_nxt.ovt_pulse   = 1'b0;
      // registers
      if (wr_acc && addr_ok) begin
         if (paddr == ADDR_CTRL) s_nxt.ctrl = pwdata[7:0];
         else if (paddr == ADDR_EXPO) s_nxt.expo_duration_us = pwdata[19:0];
         else if (paddr == ADDR_RATE) s_nxt.internal_rate_fps = pwdata[19:0];
         else if (paddr == ADDR_MAXRATE) s_nxt.max_rate_fps = pwdata[19:0];
         else if (paddr == ADDR_STATUS && pwdata[STAT_OVT])
            s_nxt.ovt_sticky = 1'b0;
      end
      if (rd_acc) begin
         s_nxt.rdata = 32'h00000000;
         if (!addr_ok) s_nxt.rdata = 32'h00000000;
         else if (paddr == ADDR_CTRL) s_nxt.rdata[7:0] = s_r.ctrl;
         else if (paddr == ADDR_EXPO)
            s_nxt.rdata[19:0] = s_r.expo_duration_us;
         else if (paddr == ADDR_RATE)
            s_nxt.rdata[19:0] = s_r.internal_rate_fps;
         else if (paddr == ADDR_MAXRATE)
            s_nxt.rdata[19:0] = s_r.max_rate_fps;
         else if (paddr == ADDR_STATUS) begin
            s_nxt.rdata[STAT_WAITING]  = (s_r.st == ASTL_WAIT);
            s_nxt.rdata[STAT_EXPOSING] = (s_r.st == ASTL_EXPOSE)
                                         | (s_r.st == ASTL_HOLD);
            s_nxt.rdata[STAT_ACTIVE]   = (s_r.st != ASTL_IDLE);
            s_nxt.rdata[STAT_OVT]      = s_r.ovt_sticky;
         end else if (paddr == ADDR_OVTCNT)
            s_nxt.rdata[15:0] = s_r.ovt_count;
      end
      // internal rate generator runs while a continuous capture is live
      if (s_r.continuous_run) begin
         if (rate_tick) begin
            s_nxt.rate_cnt = astl_period(eff_rate) - 32'h00000001; // R20
            s_nxt.pending_internal = 1'b1; // R19
         end else begin
            s_nxt.rate_cnt = s_r.rate_cnt - 32'h00000001;
         end
      end
      // state machine
      case (s_r.st)
         ASTL_IDLE: begin
            if (capture_begin_cmd) begin
               s_nxt.st = ASTL_WAIT;
               if (!trig_enable_sel) begin
                  s_nxt.pending_internal = 1'b1; // R18
                  s_nxt.continuous_run = capture_kind_sel; // R19
                  s_nxt.rate_cnt = astl_period(eff_rate)
                                   - 32'h00000001;
               end
            end
         end
         ASTL_WAIT: begin
            // only a waiting device acts on a trigger
            if (!trig_enable_sel && s_r.pending_internal) begin // R8
               s_nxt.pending_internal = 1'b0;
               s_nxt.st = ASTL_EXPOSE; // R12
               s_nxt.width_mode = 1'b0; // R1
               s_nxt.expo_cnt = expo_cycles;
               s_nxt.frame_start = 1'b1;
            end else if (trig_enable_sel && any_trig) begin // R8 R2 R15
               s_nxt.st = ASTL_EXPOSE; // R11 R12
               s_nxt.frame_start = 1'b1;
               s_nxt.expo_cnt = expo_cycles;
               // host triggers always timed; lines may follow the level
               s_nxt.width_mode = (trig_origin_sel != ASTL_ORIG_HOST)
                                  & expo_kind_sel; // R9 R10 R13
            end
         end
         ASTL_EXPOSE: begin
            // host commands here fall through unused
            if (trig_enable_sel && ext_capture_trig && !s_r.width_mode
                && trig_origin_sel != ASTL_ORIG_HOST) begin // R14 R21
               s_nxt.ovt_pulse  = 1'b1;
               s_nxt.ovt_sticky = 1'b1;
               s_nxt.ovt_count  = s_r.ovt_count + 16'h0001;
            end
            if (s_r.width_mode) begin
               if (!ext_level) s_nxt.st = ASTL_HOLD; // R10
            end else if (s_r.expo_cnt <= 32'h00000001) begin
               s_nxt.st = ASTL_HOLD;
            end else begin
               s_nxt.expo_cnt = s_r.expo_cnt - 32'h00000001;
            end
         end
         ASTL_HOLD: begin
            // one cycle of recovery, then ready again or done
            // a stopped continuous run also ends here, not in waiting
            if (!trig_enable_sel && !s_r.continuous_run
                && !s_r.pending_internal)
               s_nxt.st = ASTL_IDLE; // R18
            else
               s_nxt.st = ASTL_WAIT; // R12
         end
         default: s_nxt.st = ASTL_IDLE;
      endcase
      // stop ends acquisition, after the exposure in flight with trigger mode off; with mode on that exposure returns to waiting
      if (capture_end_cmd) begin
         s_nxt.continuous_run   = 1'b0; // R19
         s_nxt.pending_internal = 1'b0;
         if (s_r.st == ASTL_WAIT || s_r.st == ASTL_IDLE
             || s_r.st == ASTL_HOLD)
            s_nxt.st = ASTL_IDLE; // R19
      end
      if (s_nxt.st == ASTL_IDLE && s_r.st == ASTL_HOLD)
         s_nxt.continuous_run = s_r.continuous_run & ~capture_end_cmd;
      // set wins over a clear in the same cycle
      if (s_nxt.ovt_pulse) s_nxt.ovt_sticky = 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
         s_r.ctrl <= CTRL_RST;
         s_r.expo_duration_us <= EXPO_RST_US;
         s_r.internal_rate_fps <= RATE_RST;
         s_r.max_rate_fps <= MAXRATE_RST;
         s_r.st <= ASTL_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata         = s_r.rdata;
   assign pready         = 1'b1;
   assign pslverr        = psel & penable & ~addr_ok;
   assign expose_active  = (s_r.st == ASTL_EXPOSE);
   assign frame_start    = s_r.frame_start;
   assign overtrig_event = s_r.ovt_pulse;
   assign waiting_status = (s_r.st == ASTL_WAIT); // R12
endmodule
`default_nettype wire

// File: verif/astl_src.sv
/*
 partner model: external trigger source driving input lines 1 and 2.
 assumes the bench calls drive just after a pclk edge.
*/
`timescale 1ns/1ps
`default_nettype none
module astl_src (
   // clock
   input  wire logic pclk,
   // trigger lines
   output logic      line1_in,
   output logic      line2_in
);
   initial begin
      line1_in = 1'b0;
      line2_in = 1'b0;
   end
   // one level change, then held; one edge per wanted frame
   task automatic drive(input int ln, input logic lv, input int n);
      @(posedge pclk);
      if (ln == 1)
         line1_in <= lv;
      else
         line2_in <= lv;
      repeat (n) @(posedge pclk);
   endtask
endmodule
`default_nettype wire

// File: verif/astl_trigger_sva.sv
/*
 checker for the trigger block: frame outputs against their causes.
 assumes it sees only the top ports; bound at the foot of this file.
*/
`timescale 1ns/1ps
`default_nettype none
module astl_trigger_sva
   import astl_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   // frame control
   input  wire logic        expose_active,
   input  wire logic        frame_start,
   input  wire logic        overtrig_event,
   input  wire logic        waiting_status
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_start_waited: assert property (frame_start |-> $past(waiting_status))
      else $error("frame start without waiting");
   a_start_exposes: assert property (frame_start |-> expose_active)
      else $error("frame start without exposure");
   a_start_single: assert property (frame_start |=> !frame_start)
      else $error("frame start longer than one cycle");
   a_wait_excl: assert property (!(waiting_status && expose_active))
      else $error("waiting while exposing");
   a_expose_cause: assert property ($rose(expose_active) |-> frame_start)
      else $error("exposure began without frame start");
   // a host command taken outside waiting must not start a frame
   a_host_drop: assert property (psel && penable && pwrite
      && paddr == ADDR_CMD && pwdata[CMD_HOST_TRIG] && !waiting_status
      |=> !frame_start)
      else $error("host trigger acted on outside waiting");
   a_ovt_single: assert property (overtrig_event |=> !overtrig_event)
      else $error("overtrigger longer than one cycle");
   a_ovt_nostart: assert property (overtrig_event |-> !frame_start)
      else $error("overtrigger started a frame");
endmodule

bind astl_trigger astl_trigger_sva u_sva (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .expose_active(expose_active), .frame_start(frame_start),
   .overtrig_event(overtrig_event), .waiting_status(waiting_status));
`default_nettype wire

// File: verif/tb.sv
/*
 self-checking bench for the trigger block: apb master, line source.
 assumes the 10 MHz pclk and the hand-over timing of the design.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
   import astl_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        line1_in, line2_in, serr;
   logic        expose_active, frame_start, overtrig_event, waiting_status;
   int          err_count, tests_run, c, len;

   always #50 pclk = ~pclk;

   astl_trigger dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .line1_in(line1_in), .line2_in(line2_in),
      .expose_active(expose_active), .frame_start(frame_start),
      .overtrig_event(overtrig_event), .waiting_status(waiting_status));
   astl_src src (.pclk(pclk), .line1_in(line1_in), .line2_in(line2_in));

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s: expected %0h seen %0h", nm, e, g);
      end
   endtask

   task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      if (pready !== 1'b1) begin
         err_count++;
         report_and_stop();
      end
      rd = prdata;
      serr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // c: edges before the one where the flag shows, -1 if it never does within n
   task automatic wt(logic ovt, int n);
      c = -1;
      for (int i = 0; i < n && c < 0; i++) begin
         @(posedge pclk);
         if ((ovt ? overtrig_event : frame_start) === 1'b1)
            c = i;
      end
   endtask

   task automatic seen(string nm, logic e, logic ovt, int n);
      wt(ovt, n);
      chk(nm, {31'h0, e}, {31'h0, c >= 0});
      if (e && c < 0)
         report_and_stop();
   endtask

   task automatic xlen;
      len = 0;
      while (expose_active === 1'b1 && len < 2000) begin
         @(posedge pclk);
         len++;
      end
   endtask

   // resync on one frame first, so a rate change never splits a period
   task automatic per(int p);
      wt(0, 400);
      wt(0, 400);
      chk("period", 1, {31'h0, c + 1 >= p - 1 && c + 1 <= p + 1});
      if (c < 0)
         report_and_stop();
   endtask

   function automatic logic [31:0] ctl(logic en, logic [1:0] o,
                                       logic r, t, w, k, re);
      return {24'h0, re, k, w, t, r, o, en};
   endfunction

   task automatic t_regs;
      apb(0, ADDR_CTRL, 32'h0);
      chk("ctrl", {24'h0, CTRL_RST}, rd);
      apb(0, ADDR_EXPO, 32'h0);
      chk("expo", {12'h0, EXPO_RST_US}, rd);
      apb(0, ADDR_RATE, 32'h0);
      chk("rate", {12'h0, RATE_RST}, rd);
      apb(0, ADDR_MAXRATE, 32'h0);
      chk("maxrate", {12'h0, MAXRATE_RST}, rd);
      apb(1, 12'h01C, 32'hFF);
      chk("slverr", 1, {31'h0, serr});
      $display("regs done");
   endtask

   task automatic t_host;
      apb(1, ADDR_EXPO, 32'h2);
      apb(1, ADDR_CTRL, ctl(1, ASTL_ORIG_HOST, 0, 1, 0, 1, 0));
      apb(1, ADDR_CMD, 32'h1);
      apb(1, ADDR_CMD, 32'h4);
      seen("host start", 1, 0, 8);
      chk("wait off", 0, {31'h0, waiting_status});
      apb(1, ADDR_CMD, 32'h4);
      seen("dropped", 0, 0, 40);
      chk("wait back", 1, {31'h0, waiting_status});
      apb(1, ADDR_CMD, 32'h4);
      seen("host again", 1, 0, 8);
      xlen;
      chk("timed len", 2 * CYC_PER_US, len);
      @(posedge pclk);
      chk("rewait", 1, {31'h0, waiting_status});
      apb(1, ADDR_CTRL, ctl(1, ASTL_ORIG_HOST, 0, 0, 0, 1, 0));
      apb(1, ADDR_CMD, 32'h4);
      seen("off target", 0, 0, 40);
      $display("host done");
   endtask

   task automatic t_lines;
      for (int ln = 1; ln < 3; ln++) begin
         for (int r = 1; r >= 0; r--) begin
            apb(1, ADDR_CTRL, ctl(1, 2'(ln), r[0], 1, 0, 1, 0));
            src.drive(ln, !r[0], 0);
            seen("idle edge", 0, 0, 8);
            src.drive(ln, r[0], 0);
            seen("line edge", 1, 0, 8);
            repeat (30) @(posedge pclk);
            src.drive(ln, !r[0], 0);
            seen("back edge", 0, 0, 8);
         end
      end
      $display("lines done");
   endtask

   task automatic t_over;
      apb(1, ADDR_CTRL, ctl(1, ASTL_ORIG_LINE1, 1, 1, 0, 1, 0));
      src.drive(1, 0, 8);
      src.drive(1, 1, 0);
      seen("ovt start", 1, 0, 8);
      src.drive(1, 0, 2);
      src.drive(1, 1, 0);
      seen("ovt event", 1, 1, 8);
      seen("ovt ignored", 0, 0, 30);
      apb(1, ADDR_CTRL, ctl(1, ASTL_ORIG_LINE1, 1, 1, 1, 1, 0));
      src.drive(1, 0, 8);
      fork
         begin
            src.drive(1, 1, 40);
            src.drive(1, 0, 0);
         end
         begin
            seen("width start", 1, 0, 8);
            xlen;
         end
      join
      chk("width len", 1, {31'h0, len > 38 && len < 44});
      apb(0, ADDR_OVTCNT, 32'h0);
      chk("ovt count", 1, rd);
      apb(0, ADDR_STATUS, 32'h0);
      chk("status", 32'h0000000D, rd);
      apb(1, ADDR_STATUS, 32'h00000008);
      apb(0, ADDR_STATUS, 32'h0);
      chk("status clr", 32'h00000005, rd);
      $display("overtrigger done");
   endtask

   task automatic t_off;
      apb(1, ADDR_CMD, 32'h2);
      apb(1, ADDR_EXPO, 32'h3);
      apb(1, ADDR_CTRL, ctl(0, 0, 0, 1, 0, 0, 0));
      apb(1, ADDR_CMD, 32'h1);
      seen("single", 1, 0, 8);
      xlen;
      chk("off len", 3 * CYC_PER_US, len);
      seen("one only", 0, 0, 200);
      apb(1, ADDR_MAXRATE, 32'h00030D40);
      apb(1, ADDR_RATE, 32'h000186A0);
      apb(1, ADDR_CTRL, ctl(0, 0, 0, 1, 0, 1, 1));
      apb(1, ADDR_CMD, 32'h1);
      per(CLK_HZ / 100000);
      apb(1, ADDR_CTRL, ctl(0, 0, 0, 1, 0, 1, 0));
      per(CLK_HZ / 200000);
      apb(1, ADDR_CTRL, ctl(0, 0, 0, 1, 0, 1, 1));
      apb(1, ADDR_RATE, 32'h000493E0);
      per(CLK_HZ / 200000);
      wt(0, 100);
      apb(1, ADDR_CMD, 32'h2);
      seen("stopped", 0, 0, 200);
      chk("stop idle", 0, {31'h0, waiting_status});
      $display("internal done");
   endtask

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      err_count = 0;
      tests_run = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_host;
      t_lines;
      t_over;
      t_off;
      report_and_stop();
   end
endmodule
`default_nettype wire
